// ===== dv/ipc_core_model.sv
// Core-side model that takes interrupts and returns from them
`timescale 1ns/1ps
module ipc_core_model
  import ipc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_irq_high,
  input wire logic i_irq_low,
  input wire logic i_allow,
  output logic o_take,
  output logic o_return,
  output logic [PC_W-1:0] o_ret_pc,
  output logic [RW-1:0] o_wrk,
  output logic [RW-1:0] o_status,
  output logic [RW-1:0] o_bank
);
  logic busy_r;
  // Context is offered only with the entry pulse, a different pattern otherwise
  assign o_ret_pc = o_take ? 21'h012345 : 21'h1EDCBA;
  assign o_wrk = o_take ? 8'hA5 : 8'h5A;
  assign o_status = o_take ? 8'h3C : 8'hC3;
  assign o_bank = o_take ? 8'h0F : 8'hF0;
  // One entry per allowed request, one return once the bench withdraws
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'h0;
      o_take <= 1'h0;
      o_return <= 1'h0;
    end else begin
      o_take <= i_allow && !busy_r && !o_take && (i_irq_high || i_irq_low);
      busy_r <= i_allow && (busy_r || o_take);
      o_return <= busy_r && !i_allow;
    end
  end
endmodule : ipc_core_model

// ===== dv/ipc_top_tb_top.sv
// Register-level testbench of the interrupt priority block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module ipc_top_tb_top;
  import ipc_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [AW-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [DW-1:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic [RW-1:0] port = 8'h00;
  logic rxp = 1'h0, txp = 1'h0, ccp = 1'h0, wdt = 1'h0, pdn = 1'h0, allow = 1'h0;
  wire logic awready, wready, bvalid, arready, rvalid, hi, lo, wake, take, ret, full;
  wire logic [1:0] bresp, rresp;
  wire logic [DW-1:0] rdata;
  wire logic [PC_W-1:0] top_pc, rpc;
  wire logic [RW-1:0] swr, sst, sbs, cwr, cst, cbs;
  int err_total = 0, checks = 0, cyc = 0;
  logic [AW-1:0] offs [6] = '{OFF_PRIM, OFF_SEC, OFF_THIRD, OFF_PPR3, OFF_RSTC, OFF_TCTL};
  logic [RW-1:0] rsts [6] = '{PRIM_RST, SEC_RST, THIRD_RST, PPR3_RST, RSTC_RST, TCTL_RST};

  always #5 clk = ~clk;

  ipc_top i_ipc_top (.i_clk(clk), .i_rst_n(rst_n), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_port_b_pins(port),
    .i_serial2_rx_pend(rxp), .i_serial2_tx_pend(txp), .i_capcomp3_pend(ccp),
    .i_wdt_timeout(wdt), .i_power_down_entry(pdn), .i_irq_take(take), .i_irq_return(ret),
    .i_ret_pc(rpc), .i_wrk(cwr), .i_status(cst), .i_bank(cbs), .o_irq_high(hi),
    .o_irq_low(lo), .o_wake(wake), .o_top_pc(top_pc), .o_shadow_wrk(swr),
    .o_shadow_status(sst), .o_shadow_bank(sbs), .o_stack_full(full));
  ipc_core_model i_ipc_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_irq_high(hi),
    .i_irq_low(lo), .i_allow(allow), .o_take(take), .o_return(ret), .o_ret_pc(rpc),
    .o_wrk(cwr), .o_status(cst), .o_bank(cbs));

  // Register write: address and data offered together, each dropped when taken
  task automatic wr(input logic [AW-1:0] a, input logic [RW-1:0] d,
      input logic [1:0] er = RESP_OKAY);
    logic pa, pw, ta, tw, b;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    b = 1'h0;
    while (pa || pw) begin
      @(negedge clk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge clk);
      pa = pa && !ta;
      pw = pw && !tw;
      awvalid <= pa;
      wvalid <= pw;
    end
    while (!b) begin
      @(negedge clk);
      b = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 1'h0;
    `CHK("bresp", er, r)
  endtask : wr

  // Register read compared with an expected byte and response
  task automatic rd(input logic [AW-1:0] a, input logic [RW-1:0] e,
      input logic [1:0] er = RESP_OKAY);
    logic b;
    logic [DW-1:0] q;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    b = 1'h0;
    while (!b) begin
      @(negedge clk);
      b = arready;
      @(posedge clk);
    end
    arvalid <= 1'h0;
    b = 1'h0;
    while (!b) begin
      @(negedge clk);
      b = rvalid;
      q = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 1'h0;
    `CHK("rdata", {24'h000000, e}, q)
    `CHK("rresp", er, r)
  endtask : rd

  // Compare both vector requests once settled
  task automatic chk_irq(input logic h, input logic l);
    @(posedge clk);
    @(negedge clk);
    `CHK("irq_high", h, hi)
    `CHK("irq_low", l, lo)
    @(posedge clk);
  endtask : chk_irq

  // New pin levels, then time for the edge detector
  task automatic setp(input logic [RW-1:0] v);
    @(posedge clk);
    port <= v;
    repeat (3) @(posedge clk);
  endtask : setp

  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    for (int k = 0; k < 6; k++) rd(offs[k], rsts[k]);
    rd(8'h20, 8'h00, RESP_SLVERR);
    wr(8'h20, 8'hFF, RESP_SLVERR);
    // Single-level mode: pin zero goes to the high vector, core saves context
    wr(OFF_PRIM, 8'h90);
    setp(8'h01);
    rd(OFF_PRIM, 8'h92);
    chk_irq(1'h1, 1'h0);
    allow <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("top_pc", 21'h012345, top_pc)
    `CHK("shadow", 24'hA53C0F, {swr, sst, sbs})
    @(posedge clk);
    allow <= 1'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("pop", 21'h000000, top_pc)
    `CHK("full", 1'h0, full)
    // Flag cleared before re-enable, then both edge polarities
    wr(OFF_PRIM, 8'h80);
    wr(OFF_PRIM, 8'h90);
    setp(8'h00);
    rd(OFF_PRIM, 8'h90);
    wr(OFF_SEC, 8'h77);
    setp(8'h01);
    rd(OFF_PRIM, 8'h90);
    setp(8'h00);
    rd(OFF_PRIM, 8'h92);
    // Disabled pin still flags; wake without global enable
    wr(OFF_PRIM, 8'h80);
    setp(8'h01);
    setp(8'h00);
    rd(OFF_PRIM, 8'h82);
    chk_irq(1'h0, 1'h0);
    wr(OFF_PRIM, 8'h12);
    chk_irq(1'h0, 1'h0);
    @(negedge clk);
    `CHK("wake", 1'h1, wake)
    // Peripheral source needs peripheral enable in single-level mode
    wr(OFF_PRIM, 8'h80);
    ccp <= 1'h1;
    chk_irq(1'h0, 1'h0);
    wr(OFF_PRIM, 8'hC0);
    chk_irq(1'h1, 1'h0);
    ccp <= 1'h0;
    wr(OFF_PRIM, 8'h08);
    setp(8'h10);
    rd(OFF_PRIM, 8'h09);
    // Timer zero overflow, 8-bit then 16-bit
    wr(OFF_PRIM, 8'h00);
    wr(OFF_TLO, 8'hFE);
    wr(OFF_TCTL, 8'h80);
    repeat (4) @(posedge clk);
    rd(OFF_PRIM, 8'h04);
    wr(OFF_PRIM, 8'hA4);
    chk_irq(1'h1, 1'h0);
    wr(OFF_TCTL, 8'h00);
    wr(OFF_THI, 8'h00);
    wr(OFF_TLO, 8'hFE);
    wr(OFF_PRIM, 8'h00);
    wr(OFF_TCTL, 8'hC0);
    repeat (4) @(posedge clk);
    rd(OFF_PRIM, 8'h00);
    wr(OFF_TCTL, 8'h00);
    wr(OFF_THI, 8'hFF);
    wr(OFF_TLO, 8'hFE);
    wr(OFF_TCTL, 8'hC0);
    repeat (4) @(posedge clk);
    rd(OFF_PRIM, 8'h04);
    wr(OFF_TCTL, 8'h00);
    // Two priority levels
    wr(OFF_RSTC, 8'h80);
    rd(OFF_RSTC, 8'h8C);
    wr(OFF_PRIM, 8'hA4);
    wr(OFF_SEC, 8'h7B);
    chk_irq(1'h0, 1'h0);
    wr(OFF_PRIM, 8'hE4);
    chk_irq(1'h0, 1'h1);
    wr(OFF_SEC, 8'h7F);
    chk_irq(1'h1, 1'h0);
    wr(OFF_PRIM, 8'hC0);
    rxp <= 1'h1;
    chk_irq(1'h0, 1'h1);
    wr(OFF_PPR3, 8'hFF);
    rd(OFF_PPR3, 8'h31);
    chk_irq(1'h1, 1'h0);
    rxp <= 1'h0;
    txp <= 1'h1;
    wr(OFF_PPR3, 8'h21);
    chk_irq(1'h0, 1'h1);
    txp <= 1'h0;
    ccp <= 1'h1;
    chk_irq(1'h1, 1'h0);
    wr(OFF_PPR3, 8'h20);
    chk_irq(1'h0, 1'h1);
    wr(OFF_RSTC, 8'h00);
    chk_irq(1'h1, 1'h0);
    ccp <= 1'h0;
    wr(OFF_RSTC, 8'h80);
    wr(OFF_THIRD, 8'h08);
    setp(8'h12);
    chk_irq(1'h0, 1'h1);
    wr(OFF_THIRD, 8'h49);
    chk_irq(1'h1, 1'h0);
    // Reset-cause flags and their hardware clears
    wr(OFF_RSTC, 8'hFF);
    rd(OFF_RSTC, 8'hDF);
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    rd(OFF_RSTC, 8'hD7);
    pdn <= 1'h1;
    @(posedge clk);
    pdn <= 1'h0;
    rd(OFF_RSTC, 8'hD3);
    results();
  end
endmodule : ipc_top_tb_top

// ===== src/ipc_context.sv
// Return address stack and fast-return shadow registers
`timescale 1ns/1ps
module ipc_context
  import ipc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [PC_W-1:0] i_ret_pc,
  input wire logic [RW-1:0] i_wrk,
  input wire logic [RW-1:0] i_status,
  input wire logic [RW-1:0] i_bank,
  output logic [PC_W-1:0] o_top_pc,
  output logic [RW-1:0] o_shadow_wrk,
  output logic [RW-1:0] o_shadow_status,
  output logic [RW-1:0] o_shadow_bank,
  output logic o_stack_full
);

  logic [PC_W-1:0] stk [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr_r;
  wire can_push = i_push && (ptr_r != PTR_FULL);
  wire can_pop = i_pop && !i_push && (ptr_r != '0);
  wire [STK_PTR_W-1:0] below = ptr_r - PTR_ONE - PTR_ONE;

  assign o_stack_full = (ptr_r == PTR_FULL);

  // Stack storage; a push on a full stack is dropped
  always_ff @(posedge i_clk) begin
    if (can_push) begin
      stk[ptr_r] <= i_ret_pc;
    end
  end

  // Pointer, top of stack and shadow copies
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_r <= '0;
      o_top_pc <= '0;
      o_shadow_wrk <= '0;
      o_shadow_status <= '0;
      o_shadow_bank <= '0;
    end else if (i_push) begin
      if (can_push) begin
        ptr_r <= ptr_r + PTR_ONE;
        o_top_pc <= i_ret_pc;
      end
      o_shadow_wrk <= i_wrk;
      o_shadow_status <= i_status;
      o_shadow_bank <= i_bank;
    end else if (can_pop) begin
      ptr_r <= ptr_r - PTR_ONE;
      o_top_pc <= (ptr_r == PTR_ONE) ? '0 : stk[below];
    end
  end

  AST_CTX_SAVE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    can_push |=> (o_top_pc == $past(i_ret_pc)) && (o_shadow_wrk == $past(i_wrk))
      && (o_shadow_status == $past(i_status)) && (o_shadow_bank == $past(i_bank)))
    else $error("context not saved on interrupt entry");

endmodule : ipc_context

// ===== src/ipc_pkg.sv
// Constants, register map and field layout of the interrupt priority block
package ipc_pkg;

  // ------------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int RW = 8;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int STK_PTR_W = 5;
  localparam int NEXT = 4;
  localparam int NPORT_HI = 4;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [AW-1:0] OFF_PRIM = 8'h00;
  localparam logic [AW-1:0] OFF_SEC = 8'h04;
  localparam logic [AW-1:0] OFF_THIRD = 8'h08;
  localparam logic [AW-1:0] OFF_PPR3 = 8'h0C;
  localparam logic [AW-1:0] OFF_RSTC = 8'h10;
  localparam logic [AW-1:0] OFF_TCTL = 8'h14;
  localparam logic [AW-1:0] OFF_TLO = 8'h18;
  localparam logic [AW-1:0] OFF_THI = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int PRIM_GLB = 7;
  localparam int PRIM_PEN = 6;
  localparam int PRIM_T0IE = 5;
  localparam int PRIM_X0IE = 4;
  localparam int PRIM_CHG_EN = 3;
  localparam int PRIM_T0IF = 2;
  localparam int PRIM_X0IF = 1;
  localparam int PRIM_CHG_FLG = 0;
  localparam int SEC_EDGE_LSB = 3;
  localparam int SEC_T0IP = 2;
  localparam int SEC_X3IP = 1;
  localparam int SEC_CHG_PRI = 0;
  localparam int THIRD_X2IP = 7;
  localparam int THIRD_X1IP = 6;
  localparam int THIRD_XIE_LSB = 3;
  localparam int THIRD_XIF_LSB = 0;
  localparam int PPR3_RX = 5;
  localparam int PPR3_TX = 4;
  localparam int PPR3_CC3 = 0;
  localparam int RSTC_LVL = 7;
  localparam int RSTC_WDT = 3;
  localparam int RSTC_PDN = 2;
  localparam int TCTL_RUN = 7;
  localparam int TCTL_M16 = 6;
  localparam int PORT_HI_LSB = 4;

  // ------------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------------
  localparam logic [RW-1:0] PRIM_RST = 8'h00;
  localparam logic [RW-1:0] SEC_RST = 8'h7F;
  localparam logic [RW-1:0] THIRD_RST = 8'hC0;
  localparam logic [RW-1:0] PPR3_RST = 8'h01;
  localparam logic [RW-1:0] RSTC_RST = 8'h5C;
  localparam logic [RW-1:0] TCTL_RST = 8'h00;
  localparam logic [RW-1:0] ALL_WMASK = 8'hFF;
  localparam logic [RW-1:0] SEC_WMASK = 8'h7F;
  localparam logic [RW-1:0] PPR3_WMASK = 8'h31;
  localparam logic [RW-1:0] RSTC_WMASK = 8'hD3;
  localparam logic [RW-1:0] TCTL_WMASK = 8'hC0;
  localparam logic [RW-1:0] ZERO8 = 8'h00;

  // ------------------------------------------------------------------
  // Timer, bus and stack pointer constants
  // ------------------------------------------------------------------
  localparam logic [7:0] T8_MAX = 8'hFF;
  localparam logic [15:0] T16_MAX = 16'hFFFF;
  localparam logic [7:0] T_STEP8 = 8'h01;
  localparam logic [15:0] T_STEP16 = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [STK_PTR_W-1:0] PTR_ONE = 5'h01;
  localparam logic [STK_PTR_W-1:0] PTR_FULL = 5'h1F;

endpackage : ipc_pkg

// ===== src/ipc_top.sv
// Interrupt priority, pin sources, timer zero and reset-cause registers
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Peripheral priorities at bits 5, 4, 0
// - Unused priority-three bits read zero
// - Bit 7 enables two priority levels
// - Reset-cause flags held; bit 5 reads zero
// - Edge select: one rising, zero falling
// - Valid pin edge sets sticky flag
// - Pin interrupt gated by its enable
// - Enabled pin interrupt wakes the processor
// - Vectoring after wake needs global enable
// - Pins 1-3 priority from dedicated bits
// - Pin zero always high priority
// - Timer overflow sets flag, 8/16 bit
// - Timer enable bit 5, priority bit 2
// - Port B upper change sets flag
// - Entry pushes PC and shadows registers
// - Legacy peripherals need peripheral enable
// - Peripheral priorities only with levels enabled
module ipc_top
  import ipc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [DW/8-1:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [DW-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [RW-1:0] i_port_b_pins,
  input wire logic i_serial2_rx_pend,
  input wire logic i_serial2_tx_pend,
  input wire logic i_capcomp3_pend,
  input wire logic i_wdt_timeout,
  input wire logic i_power_down_entry,
  input wire logic i_irq_take,
  input wire logic i_irq_return,
  input wire logic [PC_W-1:0] i_ret_pc,
  input wire logic [RW-1:0] i_wrk,
  input wire logic [RW-1:0] i_status,
  input wire logic [RW-1:0] i_bank,
  output logic o_irq_high,
  output logic o_irq_low,
  output logic o_wake,
  output logic [PC_W-1:0] o_top_pc,
  output logic [RW-1:0] o_shadow_wrk,
  output logic [RW-1:0] o_shadow_status,
  output logic [RW-1:0] o_shadow_bank,
  output logic o_stack_full
);

  // ------------------------------------------------------------------
  // Register bus slave
  // ------------------------------------------------------------------
  logic aw_got_r, w_got_r, wbe_r, bvalid_r, rvalid_r;
  logic [AW-1:0] awaddr_r;
  logic [RW-1:0] wdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic [DW-1:0] rdata_r;
  logic [RW-1:0] prim_r, sec_r, third_r, ppr3_r, rstc_r, tctl_r;
  logic [RW-1:0] prim_nxt, third_nxt, rstc_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic [NEXT-1:0] pin_prev_r;
  logic [NPORT_HI-1:0] rb_prev_r;
  logic pins_valid_r;

  // Channel acceptance and merged write request
  assign o_awready = !aw_got_r && !bvalid_r;
  assign o_wready = !w_got_r && !bvalid_r;
  assign o_arready = !rvalid_r;
  wire aw_fire = i_awvalid && o_awready;
  wire w_fire = i_wvalid && o_wready;
  wire ar_fire = i_arvalid && o_arready;
  wire have_aw = aw_got_r || aw_fire;
  wire have_w = w_got_r || w_fire;
  wire wr_do = have_aw && have_w && !bvalid_r;
  wire [AW-1:0] wr_addr = aw_got_r ? awaddr_r : i_awaddr;
  wire [RW-1:0] wr_data = w_got_r ? wdata_r : i_wdata[RW-1:0];
  wire wr_be = w_got_r ? wbe_r : i_wstrb[0];

  // Write address decode
  wire wr_hit = wr_do && wr_be;
  wire wr_prim = wr_hit && (wr_addr == OFF_PRIM);
  wire wr_sec = wr_hit && (wr_addr == OFF_SEC);
  wire wr_third = wr_hit && (wr_addr == OFF_THIRD);
  wire wr_ppr3 = wr_hit && (wr_addr == OFF_PPR3);
  wire wr_rstc = wr_hit && (wr_addr == OFF_RSTC);
  wire wr_tctl = wr_hit && (wr_addr == OFF_TCTL);
  wire wr_tlo = wr_hit && (wr_addr == OFF_TLO);
  wire wr_thi = wr_hit && (wr_addr == OFF_THI);
  wire wr_mapped = (wr_addr == OFF_PRIM) || (wr_addr == OFF_SEC) ||
    (wr_addr == OFF_THIRD) || (wr_addr == OFF_PPR3) || (wr_addr == OFF_RSTC) ||
    (wr_addr == OFF_TCTL) || (wr_addr == OFF_TLO) || (wr_addr == OFF_THI);

  // Read decode; unused bits are never stored so they read zero
  wire rd_mapped = (i_araddr == OFF_PRIM) || (i_araddr == OFF_SEC) ||
    (i_araddr == OFF_THIRD) || (i_araddr == OFF_PPR3) || (i_araddr == OFF_RSTC) ||
    (i_araddr == OFF_TCTL) || (i_araddr == OFF_TLO) || (i_araddr == OFF_THI);
  wire [RW-1:0] rd_val =
    (i_araddr == OFF_PRIM) ? prim_r :
    (i_araddr == OFF_SEC) ? sec_r :
    (i_araddr == OFF_THIRD) ? third_r :
    (i_araddr == OFF_PPR3) ? ppr3_r :
    (i_araddr == OFF_RSTC) ? rstc_r :
    (i_araddr == OFF_TCTL) ? tctl_r :
    (i_araddr == OFF_TLO) ? tcnt_r[7:0] :
    (i_araddr == OFF_THI) ? tcnt_r[15:8] : ZERO8;

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_rvalid = rvalid_r;
  assign o_rresp = rresp_r;
  assign o_rdata = rdata_r;

  // Write channel holding and response
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wbe_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_got_r <= 1'b1;
          awaddr_r <= i_awaddr;
        end
        if (w_fire) begin
          w_got_r <= 1'b1;
          wdata_r <= i_wdata[RW-1:0];
          wbe_r <= i_wstrb[0];
        end
        if (bvalid_r && i_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // Read channel
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {{(DW-RW){1'b0}}, rd_val};
      rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Event sources
  // ------------------------------------------------------------------
  function automatic logic [RW-1:0] wmerge(input logic [RW-1:0] old,
      input logic [RW-1:0] wd, input logic [RW-1:0] m);
    wmerge = (wd & m) | (old & ~m);
  endfunction : wmerge

  wire [NEXT-1:0] pins = i_port_b_pins[NEXT-1:0];
  wire [NEXT-1:0] edge_sel = sec_r[SEC_EDGE_LSB +: NEXT];
  wire [NPORT_HI-1:0] rb_hi = i_port_b_pins[PORT_HI_LSB +: NPORT_HI];

  // Pin edge detection per pin, direction chosen by its select bit
  logic [NEXT-1:0] ext_hit;
  for (genvar k = 0; k < NEXT; k++) begin : g_edge
    assign ext_hit[k] = pins_valid_r && (edge_sel[k] ?
      (pins[k] && !pin_prev_r[k]) : (!pins[k] && pin_prev_r[k]));
  end

  // Port B change and timer overflow events
  wire rb_hit = pins_valid_r && (rb_hi != rb_prev_r);
  wire t_run = tctl_r[TCTL_RUN];
  wire t_m16 = tctl_r[TCTL_M16];
  wire t_ovf = t_run && !wr_tlo && !wr_thi &&
    (t_m16 ? (tcnt_r == T16_MAX) : (tcnt_r[7:0] == T8_MAX));

  // Flag registers: hardware set wins over a software write
  always_comb begin
    prim_nxt = wr_prim ? wr_data : prim_r;
    prim_nxt[PRIM_X0IF] = prim_nxt[PRIM_X0IF] | ext_hit[0];
    prim_nxt[PRIM_T0IF] = prim_nxt[PRIM_T0IF] | t_ovf;
    prim_nxt[PRIM_CHG_FLG] = prim_nxt[PRIM_CHG_FLG] | rb_hit;
    third_nxt = wr_third ? wr_data : third_r;
    third_nxt[THIRD_XIF_LSB +: NEXT-1] = third_nxt[THIRD_XIF_LSB +: NEXT-1] |
      ext_hit[NEXT-1:1];
    rstc_nxt = wr_rstc ? wmerge(rstc_r, wr_data, RSTC_WMASK) : rstc_r;
    rstc_nxt[RSTC_WDT] = rstc_r[RSTC_WDT] && !i_wdt_timeout;
    rstc_nxt[RSTC_PDN] = rstc_r[RSTC_PDN] && !i_power_down_entry;
  end

  // Timer zero counter; a software write wins over counting
  always_comb begin
    tcnt_nxt = tcnt_r;
    if (wr_tlo || wr_thi) begin
      if (wr_tlo) tcnt_nxt[7:0] = wr_data;
      if (wr_thi) tcnt_nxt[15:8] = wr_data;
    end else if (t_run && t_m16) begin
      tcnt_nxt = tcnt_r + T_STEP16;
    end else if (t_run) begin
      tcnt_nxt[7:0] = tcnt_r[7:0] + T_STEP8;
    end
  end

  // Register state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prim_r <= PRIM_RST;
      sec_r <= SEC_RST;
      third_r <= THIRD_RST;
      ppr3_r <= PPR3_RST;
      rstc_r <= RSTC_RST;
      tctl_r <= TCTL_RST;
      tcnt_r <= '0;
    end else begin
      prim_r <= prim_nxt;
      third_r <= third_nxt;
      rstc_r <= rstc_nxt;
      tcnt_r <= tcnt_nxt;
      if (wr_sec) sec_r <= wmerge(sec_r, wr_data, SEC_WMASK);
      if (wr_ppr3) ppr3_r <= wmerge(ppr3_r, wr_data, PPR3_WMASK);
      if (wr_tctl) tctl_r <= wmerge(tctl_r, wr_data, TCTL_WMASK);
    end
  end

  // Previous pin levels; edges are ignored until one sample is held
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev_r <= '0;
      rb_prev_r <= '0;
      pins_valid_r <= 1'b0;
    end else begin
      pin_prev_r <= pins;
      rb_prev_r <= rb_hi;
      pins_valid_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Priority resolution and requests to the core
  // ------------------------------------------------------------------
  wire glb_en = prim_r[PRIM_GLB];
  wire per_en = prim_r[PRIM_PEN];
  wire lvl_en = rstc_r[RSTC_LVL];
  wire [NEXT-1:0] ext_flag = {third_r[THIRD_XIF_LSB +: NEXT-1], prim_r[PRIM_X0IF]};
  wire [NEXT-1:0] ext_en = {third_r[THIRD_XIE_LSB +: NEXT-1], prim_r[PRIM_X0IE]};
  wire [NEXT-1:0] ext_act = ext_flag & ext_en;
  wire [NEXT-1:0] ext_hi = {sec_r[SEC_X3IP], third_r[THIRD_X2IP],
    third_r[THIRD_X1IP], 1'b1};
  wire t_act = prim_r[PRIM_T0IF] && prim_r[PRIM_T0IE];
  wire rb_act = prim_r[PRIM_CHG_FLG] && prim_r[PRIM_CHG_EN];
  wire [2:0] per_act = {i_serial2_rx_pend, i_serial2_tx_pend, i_capcomp3_pend};
  wire [2:0] per_hi = {ppr3_r[PPR3_RX], ppr3_r[PPR3_TX], ppr3_r[PPR3_CC3]};
  wire core_any = (|ext_act) || t_act || rb_act;
  wire hi_pend = (|(ext_act & ext_hi)) || (t_act && sec_r[SEC_T0IP]) ||
    (rb_act && sec_r[SEC_CHG_PRI]) || (|(per_act & per_hi));
  wire lo_pend = (|(ext_act & ~ext_hi)) || (t_act && !sec_r[SEC_T0IP]) ||
    (rb_act && !sec_r[SEC_CHG_PRI]) || (|(per_act & ~per_hi));
  wire legacy_req = core_any || (per_en && (|per_act));

  assign o_irq_high = glb_en && (lvl_en ? hi_pend : legacy_req);
  assign o_irq_low = glb_en && lvl_en && per_en && lo_pend;
  assign o_wake = core_any || (|per_act);

  // Entry context save
  ipc_context i_ipc_context (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_push(i_irq_take),
    .i_pop(i_irq_return),
    .i_ret_pc(i_ret_pc),
    .i_wrk(i_wrk),
    .i_status(i_status),
    .i_bank(i_bank),
    .o_top_pc(o_top_pc),
    .o_shadow_wrk(o_shadow_wrk),
    .o_shadow_status(o_shadow_status),
    .o_shadow_bank(o_shadow_bank),
    .o_stack_full(o_stack_full)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_rise0;
    pins_valid_r && edge_sel[0] && !pin_prev_r[0] && pins[0];
  endsequence
  sequence s_fall1;
    pins_valid_r && !edge_sel[1] && pin_prev_r[1] && !pins[1];
  endsequence
  sequence s_t8_wrap;
    t_run && !t_m16 && (tcnt_r[7:0] == T8_MAX) && !wr_tlo && !wr_thi;
  endsequence

  AST_PPR3_READ: assert property (ar_fire && (i_araddr == OFF_PPR3) |=>
    (o_rdata[7:6] == 2'h0) && (o_rdata[3:1] == 3'h0) && o_rvalid)
    else $error("priority-three unused bits not zero");
  AST_RSTC_READ: assert property (ar_fire && (i_araddr == OFF_RSTC) |=>
    !o_rdata[5] && (o_rdata[RSTC_LVL] == $past(lvl_en)))
    else $error("reset-cause readback wrong");
  AST_RISE_SETS: assert property (s_rise0 |=> prim_r[PRIM_X0IF])
    else $error("rising edge missed on pin zero");
  AST_FALL_SETS: assert property (s_fall1 |=> third_r[THIRD_XIF_LSB])
    else $error("falling edge missed on pin one");
  AST_FLAG_STICKY: assert property (third_r[THIRD_XIF_LSB] && !wr_third |=>
    third_r[THIRD_XIF_LSB])
    else $error("pin flag dropped without software clear");
  AST_QUIET: assert property ((ext_en == '0) && !t_act && !rb_act &&
    (per_act == '0) |-> !o_irq_high && !o_irq_low && !o_wake)
    else $error("request without enabled source");
  AST_WAKE: assert property (ext_flag[2] && ext_en[2] |-> o_wake)
    else $error("enabled pin did not wake");
  AST_NO_GLB: assert property (!glb_en |-> !o_irq_high && !o_irq_low)
    else $error("vector request with global enable clear");
  AST_PIN0_HIGH: assert property (glb_en && ext_act[0] |-> o_irq_high)
    else $error("pin zero not high priority");
  AST_T8_WRAP: assert property (s_t8_wrap |=> prim_r[PRIM_T0IF] &&
    (tcnt_r[7:0] == ZERO8))
    else $error("timer wrap did not set flag");
  AST_RB_CHANGE: assert property (pins_valid_r && (rb_hi != rb_prev_r) |=>
    prim_r[PRIM_CHG_FLG])
    else $error("port change missed");
  AST_LEGACY: assert property (!lvl_en |-> !o_irq_low)
    else $error("low vector used in legacy mode");
  AST_LEGACY_PEN: assert property (!lvl_en && !per_en && !core_any |->
    !o_irq_high)
    else $error("peripheral request without peripheral enable");
  AST_BRESP: assert property (wr_do |=> o_bvalid &&
    (o_bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR)))
    else $error("write response missing");

endmodule : ipc_top
